// ===== hw/rx_port_irq_pkg.sv
// Purpose: Shared constants and carriers for the receive-port interrupt flag block.
// Assumes: Register space is 8-bit addressed, 8-bit data, as seen behind the serial control bus.
// Notes: Bit positions below are shared by enable and status registers of the same half.
package rx_port_irq_pkg;

	// Register offsets
	localparam logic [7:0] PORT_IRQ_ENABLE_HIGH_OFS = 8'hd8;
	localparam logic [7:0] PORT_IRQ_ENABLE_LOW_OFS = 8'hd9;
	localparam logic [7:0] PORT_IRQ_STATUS_HIGH_OFS = 8'hda;
	localparam logic [7:0] PORT_IRQ_STATUS_LOW_OFS = 8'hdb;

	// High half field positions (enable and status)
	localparam int ENCODING_ERROR_BIT = 2;
	localparam int CTRL_CHANNEL_SEQUENCE_BIT = 1;
	localparam int CTRL_CHANNEL_CHECKSUM_BIT = 0;

	// Low half field positions (enable and status)
	localparam int LINE_LENGTH_CHANGE_BIT = 6;
	localparam int LINE_COUNT_CHANGE_BIT = 5;
	localparam int RX_OVERFLOW_BIT = 4;
	localparam int PARITY_ERROR_BIT = 2;
	localparam int PORT_VALID_CHANGE_BIT = 1;
	localparam int LOCK_CHANGE_BIT = 0;

	// Implemented bits; everything else is reserved
	localparam logic [7:0] ENABLE_HIGH_MASK = 8'h07;
	localparam logic [7:0] ENABLE_LOW_MASK = 8'hff;
	localparam logic [7:0] STATUS_HIGH_MASK = 8'h07;
	localparam logic [7:0] STATUS_LOW_MASK = 8'h77;

	// Reset values
	localparam logic [7:0] ENABLE_HIGH_RESET = 8'h00;
	localparam logic [7:0] ENABLE_LOW_RESET = 8'h00;
	localparam logic [7:0] STATUS_HIGH_RESET = 8'h00;
	localparam logic [7:0] STATUS_LOW_RESET = 8'h00;

	// Event pulses from the receive-port detectors, one cycle each
	typedef struct packed {
		logic parity_error;
		logic encoding_error;
		logic ctrl_channel_sequence;
		logic ctrl_channel_checksum;
		logic line_length_change;
		logic line_count_change;
		logic rx_overflow;
	} rx_events_t;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Whole block state
	typedef struct packed {
		logic [7:0] enable_high;
		logic [7:0] enable_low;
		logic [7:0] status_high;
		logic [7:0] status_low;
		logic lock_prev;
		logic valid_prev;
		logic primed;
		logic [7:0] rdata;
		logic rvalid;
		logic irq;
	} irq_state_t;

endpackage

// ===== hw/rx_port_interrupt_flags.sv
// Purpose: Per receive-port interrupt enables, sticky status flags and interrupt request.
// Assumes: Event inputs, level inputs and register strobes come from logic on clock_i.
// Notes: Status flags clear only on reads of the two port status registers, signalled in.
//
// Contract
// R1 - Parity errors raise the port interrupt when low enable bit 2 is set.
// R2 - Port-valid changes either way raise interrupt when low enable bit 1 set.
// R3 - Every lock state change raises interrupt when low enable bit 0 set.
// R4 - High status bit 2 sets on encoding error, clears on status-two read.
// R5 - High status bit 1 sets on sequence error, clears on status-one read.
// R6 - High status bit 0 sets on control frame CRC fail, clears on status-one read.
// R7 - Low status bit 6 sets on line length change, clears on status-two read.
// R8 - Low status bit 5 sets on line count change, clears on status-two read.
// R9 - Low status bit 4 sets on buffer overflow, clears on status-two read.
// R10 - Low status bit 2 sets on parity error, clears on status-one read.
// R11 - Low status bit 0 sets on lock change, clears on status-one read.
// R12 - Low status bit 1 sets on port valid change, clears on status-one read.
// R13 - High enable register holds encoding, sequence and CRC interrupt enables.
// R14 - Low enable register holds line length, line count, overflow enables.
// R15 - Interrupt asserted while any enabled status bit set; reserved status reads zero.
`timescale 1ns/10ps
module rx_port_interrupt_flags
	import rx_port_irq_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Register access behind the serial control bus
	input wire reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Reads of the port status registers elsewhere in the port
	input wire logic port_status_one_read_i,
	input wire logic port_status_two_read_i,
	// Receive-port event sources
	input wire rx_events_t rx_events_i,
	input wire logic rx_lock_i,
	input wire logic rx_port_valid_i,
	// Interrupt request
	output logic port_irq_o
);

	irq_state_t s_q;
	irq_state_t s_d;

	// Address match, used for both reads and writes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// Change detectors; suppressed in the first cycle after reset, since the
	// previous level is only a reset constant and would fake a change
	logic lock_change;
	logic valid_change;
	assign lock_change = s_q.primed && (rx_lock_i != s_q.lock_prev); // see R3
	assign valid_change = s_q.primed && (rx_port_valid_i != s_q.valid_prev); // see R2

	// Next-state logic
	always_comb begin
		logic [7:0] set_high;
		logic [7:0] set_low;
		logic [7:0] clr_high;
		logic [7:0] clr_low;
		s_d = s_q;
		set_high = 8'h00;
		set_low = 8'h00;
		clr_high = 8'h00;
		clr_low = 8'h00;
		s_d.lock_prev = rx_lock_i;
		s_d.valid_prev = rx_port_valid_i;
		s_d.primed = 1'b1;

		// Event sources onto status bit positions
		set_high[ENCODING_ERROR_BIT] = rx_events_i.encoding_error; // see R4
		set_high[CTRL_CHANNEL_SEQUENCE_BIT] = rx_events_i.ctrl_channel_sequence; // see R5
		set_high[CTRL_CHANNEL_CHECKSUM_BIT] = rx_events_i.ctrl_channel_checksum; // see R6
		set_low[LINE_LENGTH_CHANGE_BIT] = rx_events_i.line_length_change; // see R7
		set_low[LINE_COUNT_CHANGE_BIT] = rx_events_i.line_count_change; // see R8
		set_low[RX_OVERFLOW_BIT] = rx_events_i.rx_overflow; // see R9
		set_low[PARITY_ERROR_BIT] = rx_events_i.parity_error; // see R10
		set_low[LOCK_CHANGE_BIT] = lock_change; // see R11
		set_low[PORT_VALID_CHANGE_BIT] = valid_change; // see R12

		// Each status bit is cleared by the read of the register that reports it
		if (port_status_one_read_i) begin
			clr_high[CTRL_CHANNEL_SEQUENCE_BIT] = 1'b1; // see R5
			clr_high[CTRL_CHANNEL_CHECKSUM_BIT] = 1'b1; // see R6
			clr_low[PARITY_ERROR_BIT] = 1'b1; // see R10
			clr_low[LOCK_CHANGE_BIT] = 1'b1; // see R11
			clr_low[PORT_VALID_CHANGE_BIT] = 1'b1; // see R12
		end
		if (port_status_two_read_i) begin
			clr_high[ENCODING_ERROR_BIT] = 1'b1; // see R4
			clr_low[LINE_LENGTH_CHANGE_BIT] = 1'b1; // see R7
			clr_low[LINE_COUNT_CHANGE_BIT] = 1'b1; // see R8
			clr_low[RX_OVERFLOW_BIT] = 1'b1; // see R9
		end

		// Set wins over clear so an event in the clearing cycle is kept
		s_d.status_high = ((s_q.status_high & ~clr_high) | set_high) & STATUS_HIGH_MASK;
		s_d.status_low = ((s_q.status_low & ~clr_low) | set_low) & STATUS_LOW_MASK; // see R15

		// Enable register writes; high reserved bits are not stored
		if (reg_req_i.wr && hit(reg_req_i.addr, PORT_IRQ_ENABLE_HIGH_OFS)) begin
			s_d.enable_high = reg_req_i.wdata & ENABLE_HIGH_MASK; // see R13
		end
		if (reg_req_i.wr && hit(reg_req_i.addr, PORT_IRQ_ENABLE_LOW_OFS)) begin
			s_d.enable_low = reg_req_i.wdata & ENABLE_LOW_MASK; // see R14
		end

		// Read data one cycle after the strobe; unmapped addresses read zero
		s_d.rvalid = reg_req_i.rd;
		s_d.rdata = 8'h00;
		if (reg_req_i.rd) begin
			if (hit(reg_req_i.addr, PORT_IRQ_ENABLE_HIGH_OFS)) begin
				s_d.rdata = s_q.enable_high;
			end else if (hit(reg_req_i.addr, PORT_IRQ_ENABLE_LOW_OFS)) begin
				s_d.rdata = s_q.enable_low;
			end else if (hit(reg_req_i.addr, PORT_IRQ_STATUS_HIGH_OFS)) begin
				s_d.rdata = s_q.status_high;
			end else if (hit(reg_req_i.addr, PORT_IRQ_STATUS_LOW_OFS)) begin
				s_d.rdata = s_q.status_low;
			end
		end

		// Request follows the new flags so it rises with the status bit
		s_d.irq = |(s_d.status_high & s_d.enable_high) |
			|(s_d.status_low & s_d.enable_low); // see R1, R2, R3, R15
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s_q.enable_high <= ENABLE_HIGH_RESET;
			s_q.enable_low <= ENABLE_LOW_RESET;
			s_q.status_high <= STATUS_HIGH_RESET;
			s_q.status_low <= STATUS_LOW_RESET;
			s_q.lock_prev <= 1'b0;
			s_q.valid_prev <= 1'b0;
			s_q.primed <= 1'b0;
			s_q.rdata <= 8'h00;
			s_q.rvalid <= 1'b0;
			s_q.irq <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata_o = s_q.rdata;
	assign reg_rvalid_o = s_q.rvalid;
	assign port_irq_o = s_q.irq;

	// Checks
	AST_PARITY_IRQ: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R1
		rx_events_i.parity_error && s_d.enable_low[PARITY_ERROR_BIT] |=> port_irq_o)
		else $error("parity error with enable did not raise interrupt");

	AST_VALID_CHANGE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R2
		s_q.primed && $changed(rx_port_valid_i) && s_q.enable_low[PORT_VALID_CHANGE_BIT]
		&& !reg_req_i.wr |=> s_q.status_low[PORT_VALID_CHANGE_BIT] && port_irq_o)
		else $error("port valid change not flagged");

	AST_LOCK_CHANGE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R3
		s_q.primed && (rx_lock_i != s_q.lock_prev) |=> s_q.status_low[LOCK_CHANGE_BIT])
		else $error("lock change not flagged");

	AST_ENC_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R4
		s_q.status_high[ENCODING_ERROR_BIT] && !port_status_two_read_i
		|=> s_q.status_high[ENCODING_ERROR_BIT])
		else $error("encoding flag lost without status two read");

	AST_SEQ_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R5
		port_status_one_read_i && !rx_events_i.ctrl_channel_sequence
		|=> !s_q.status_high[CTRL_CHANNEL_SEQUENCE_BIT])
		else $error("sequence flag not cleared by status one read");

	AST_CRC_SET_WINS: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R6
		rx_events_i.ctrl_channel_checksum |=> s_q.status_high[CTRL_CHANNEL_CHECKSUM_BIT])
		else $error("checksum event lost");

	AST_OVERFLOW_NOT_ONE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R9
		s_q.status_low[RX_OVERFLOW_BIT] && port_status_one_read_i && !port_status_two_read_i
		|=> s_q.status_low[RX_OVERFLOW_BIT])
		else $error("overflow flag cleared by wrong register read");

	AST_LINE_LEN_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R7
		port_status_two_read_i && !rx_events_i.line_length_change
		|=> !s_q.status_low[LINE_LENGTH_CHANGE_BIT])
		else $error("line length flag not cleared");

	AST_RESERVED_ZERO: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R15
		reg_rvalid_o && $past(reg_req_i.addr) == PORT_IRQ_STATUS_LOW_OFS
		|-> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0)
		else $error("reserved status bit read nonzero");

	AST_IRQ_MASKED: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R15
		port_irq_o |-> |(s_q.status_high & s_q.enable_high) | |(s_q.status_low & s_q.enable_low))
		else $error("interrupt without enabled status");

	AST_ENABLE_WRITE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R14
		reg_req_i.wr && reg_req_i.addr == PORT_IRQ_ENABLE_LOW_OFS
		|=> s_q.enable_low == $past(reg_req_i.wdata))
		else $error("low enable write not stored");

	// Set side of the remaining flags: an event always lands, whatever the enables say
	AST_ENC_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R4
		rx_events_i.encoding_error |=> s_q.status_high[ENCODING_ERROR_BIT])
		else $error("encoding event lost");

	AST_SEQ_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R5
		rx_events_i.ctrl_channel_sequence |=> s_q.status_high[CTRL_CHANNEL_SEQUENCE_BIT])
		else $error("sequence event lost");

	AST_LINE_LEN_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R7
		rx_events_i.line_length_change |=> s_q.status_low[LINE_LENGTH_CHANGE_BIT])
		else $error("line length event lost");

	AST_LINE_CNT_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R8
		rx_events_i.line_count_change |=> s_q.status_low[LINE_COUNT_CHANGE_BIT])
		else $error("line count event lost");

	AST_OVERFLOW_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R9
		rx_events_i.rx_overflow |=> s_q.status_low[RX_OVERFLOW_BIT])
		else $error("overflow event lost");

	AST_PARITY_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R10
		rx_events_i.parity_error |=> s_q.status_low[PARITY_ERROR_BIT])
		else $error("parity event lost");

	AST_VALID_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R12
		valid_change |=> s_q.status_low[PORT_VALID_CHANGE_BIT])
		else $error("port valid change lost");

	// Clear side: the right read drops a flag unless a new event arrives with it
	AST_CRC_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R6
		port_status_one_read_i && !rx_events_i.ctrl_channel_checksum
		|=> !s_q.status_high[CTRL_CHANNEL_CHECKSUM_BIT])
		else $error("checksum flag not cleared by status one read");

	AST_LINE_CNT_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R8
		port_status_two_read_i && !rx_events_i.line_count_change
		|=> !s_q.status_low[LINE_COUNT_CHANGE_BIT])
		else $error("line count flag not cleared");

	AST_OVERFLOW_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R9
		port_status_two_read_i && !rx_events_i.rx_overflow
		|=> !s_q.status_low[RX_OVERFLOW_BIT])
		else $error("overflow flag not cleared");

	AST_PARITY_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R10
		port_status_one_read_i && !rx_events_i.parity_error
		|=> !s_q.status_low[PARITY_ERROR_BIT])
		else $error("parity flag not cleared");

	AST_LOCK_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R11
		port_status_one_read_i && !lock_change
		|=> !s_q.status_low[LOCK_CHANGE_BIT])
		else $error("lock change flag not cleared");

	AST_VALID_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R12
		port_status_one_read_i && !valid_change
		|=> !s_q.status_low[PORT_VALID_CHANGE_BIT])
		else $error("port valid flag not cleared");

	// A read of the other status register must leave the flag alone
	AST_PARITY_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R10
		s_q.status_low[PARITY_ERROR_BIT] && !port_status_one_read_i
		|=> s_q.status_low[PARITY_ERROR_BIT])
		else $error("parity flag lost without status one read");

	// Enables and the request; masking is the only thing the enables do
	AST_ENABLE_HIGH_WRITE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R13
		reg_req_i.wr && reg_req_i.addr == PORT_IRQ_ENABLE_HIGH_OFS
		|=> s_q.enable_high == ($past(reg_req_i.wdata) & ENABLE_HIGH_MASK))
		else $error("high enable write not stored");

	AST_LOCK_IRQ: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R3
		lock_change && s_q.enable_low[LOCK_CHANGE_BIT] && !reg_req_i.wr
		|=> s_q.status_low[LOCK_CHANGE_BIT] && port_irq_o)
		else $error("lock change with enable did not raise interrupt");

	AST_IRQ_OFF_MASKED: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R15
		s_q.enable_high == 8'h00 && s_q.enable_low == 8'h00 && !reg_req_i.wr |=> !port_irq_o)
		else $error("interrupt with all enables clear");

	AST_IRQ_FALLS_ON_READS: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R15
		port_status_one_read_i && port_status_two_read_i && rx_events_i == '0
		&& !lock_change && !valid_change |=> !port_irq_o)
		else $error("interrupt stayed after both status reads");

	AST_STATUS_HIGH_RESERVED: assert property (@(posedge clock_i) disable iff (sys_rst_i) // see R15
		reg_rvalid_o && $past(reg_req_i.addr) == PORT_IRQ_STATUS_HIGH_OFS
		|-> reg_rdata_o[7:3] == 5'h00)
		else $error("reserved high status bit read nonzero");

	// Main scenarios
	COV_IRQ_RAISED: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		!port_irq_o ##1 port_irq_o);
	COV_SET_AND_CLEAR: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		rx_events_i.parity_error && port_status_one_read_i);
	COV_IRQ_DROPS_ON_READ: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		port_irq_o && port_status_two_read_i ##1 !port_irq_o);
	COV_LOCK_FALLS: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		lock_change && !rx_lock_i);
	COV_ALL_FLAGS_SET: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		s_q.status_high == STATUS_HIGH_MASK && s_q.status_low == STATUS_LOW_MASK);

endmodule

// ===== sim/host_model.sv
// Purpose: Host side of the register path, issuing single-edge reads and writes.
// Assumes: A strobe is taken on the one rising edge where it is high.
// Notes: Address and data are scrambled after release so stale values never look valid.
`timescale 1ns/10ps
module host_model
	import rx_port_irq_pkg::*;
(
	// Clock
	input wire logic clock_i,
	// Register access toward the block
	output reg_req_t reg_req_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_rvalid_i
);
	// Bus idles with no strobe
	initial reg_req_o = '0;

	// One access: strobe for one edge, then release and sample the answer
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata, output logic ok);
		@(posedge clock_i);
		reg_req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
		@(posedge clock_i);
		reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
		#1;
		rdata = reg_rdata_i;
		ok = reg_rvalid_i;
	endtask
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the receive-port interrupt flag block.
// Assumes: Events, level changes and clear strobes last one clock each.
// Notes: Shadow status applies clears before sets, since a set wins in one cycle.
`timescale 1ns/10ps
module testbench import rx_port_irq_pkg::*;;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic s1 = 1'b0, s2 = 1'b0, lock = 1'b0, pv = 1'b0;
	rx_events_t ev = '0;
	reg_req_t req;
	logic [7:0] rdata, d, sh = 8'h00, sl = 8'h00, eh = 8'h00, el = 8'h00;
	logic rvalid, irq, ok;
	int error_cnt = 0, n_checks = 0;

	// Block under test and the host on its register side
	rx_port_interrupt_flags rx_port_interrupt_flags_inst (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.port_status_one_read_i(s1), .port_status_two_read_i(s2), .rx_events_i(ev),
		.rx_lock_i(lock), .rx_port_valid_i(pv), .port_irq_o(irq));
	host_model host_model_inst (.clock_i(clock_i), .reg_req_o(req), .reg_rdata_i(rdata),
		.reg_rvalid_i(rvalid));

	// 200 MHz clock
	initial forever #2.5 clock_i = ~clock_i;

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
		host_model_inst.access(1'b0, addr, 8'h00, d, ok);
		chk1("read valid", 1'b1, ok);
		chk8("read data", exp, d);
	endtask
	task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
		host_model_inst.access(1'b1, addr, data, d, ok);
		chk1("write answer", 1'b0, ok);
	endtask
	// Interrupt is the OR of every enabled, implemented status bit
	function automatic logic exp_irq();
		return |((sh & eh & STATUS_HIGH_MASK) | (sl & el & STATUS_LOW_MASK));
	endfunction
	function automatic logic [7:0] set_low(input rx_events_t e, input logic fv, input logic fl);
		return {1'b0, e.line_length_change, e.line_count_change, e.rx_overflow, 1'b0,
			e.parity_error, fv, fl};
	endfunction
	// One cycle of events, level flips and clear strobes, then the irq check
	task automatic step(input rx_events_t e, input logic fl, input logic fv, input logic c1,
		input logic c2);
		@(posedge clock_i);
		ev <= e;
		lock <= lock ^ fl;
		pv <= pv ^ fv;
		s1 <= c1;
		s2 <= c2;
		@(posedge clock_i);
		ev <= '0;
		s1 <= 1'b0;
		s2 <= 1'b0;
		#1;
		sh = (sh & ~{5'h0, c2, c1, c1}) | {5'h0, e.encoding_error, e.ctrl_channel_sequence,
			e.ctrl_channel_checksum};
		sl = (sl & ~{1'b0, {3{c2}}, 1'b0, {3{c1}}}) | set_low(e, fv, fl);
		chk1("irq", exp_irq(), irq);
	endtask
	task automatic check_status();
		reg_rd(PORT_IRQ_STATUS_HIGH_OFS, sh);
		reg_rd(PORT_IRQ_STATUS_LOW_OFS, sl);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		void'($urandom(32'hdb603f7b));
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		reg_rd(PORT_IRQ_ENABLE_HIGH_OFS, ENABLE_HIGH_RESET);
		reg_rd(PORT_IRQ_ENABLE_LOW_OFS, ENABLE_LOW_RESET);
		check_status();
		reg_rd(8'h42, 8'h00);
		$display("test reset_values done");
		// Reserved high enable bits drop, low enable keeps all eight bits, the low status register ignores writes
		reg_wr(PORT_IRQ_ENABLE_HIGH_OFS, 8'hff);
		reg_rd(PORT_IRQ_ENABLE_HIGH_OFS, 8'h07);
		reg_wr(PORT_IRQ_STATUS_LOW_OFS, 8'hff);
		reg_rd(PORT_IRQ_STATUS_LOW_OFS, 8'h00);
		reg_wr(PORT_IRQ_ENABLE_LOW_OFS, 8'hff);
		reg_rd(PORT_IRQ_ENABLE_LOW_OFS, 8'hff);
		eh = 8'h07;
		el = 8'hff;
		$display("test access_kinds done");
		// Each source twice (both level directions), then the wrong and the right clear
		for (int k = 0; k < 18; k++) begin
			step(rx_events_t'((k % 9) < 7 ? 7'h01 << (k % 9) : 7'h00), (k % 9) == 7,
				(k % 9) == 8, 1'b0, 1'b0);
			check_status();
			step('0, 1'b0, 1'b0, k < 9, k >= 9);
			check_status();
			step('0, 1'b0, 1'b0, 1'b1, 1'b1);
		end
		// Set and clear in the same cycle: set must win
		step(rx_events_t'(7'h7f), 1'b1, 1'b1, 1'b1, 1'b1);
		check_status();
		$display("test directed_sources done");
		for (int i = 0; i < 60; i++) begin
			eh = 8'($urandom);
			el = 8'($urandom);
			reg_wr(PORT_IRQ_ENABLE_HIGH_OFS, eh);
			reg_wr(PORT_IRQ_ENABLE_LOW_OFS, el);
			eh = eh & ENABLE_HIGH_MASK;
			step(rx_events_t'(7'($urandom & $urandom & $urandom)), $urandom % 4 == 0,
				$urandom % 4 == 0, $urandom % 3 == 0, $urandom % 3 == 0);
			check_status();
		end
		$display("test random_traffic done");
		// Mid-run reset with lock and valid left where they are: no false change after it
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		sh = STATUS_HIGH_RESET;
		sl = STATUS_LOW_RESET;
		eh = ENABLE_HIGH_RESET;
		el = ENABLE_LOW_RESET;
		step('0, 1'b0, 1'b0, 1'b0, 1'b0);
		check_status();
		reg_rd(PORT_IRQ_ENABLE_HIGH_OFS, ENABLE_HIGH_RESET);
		reg_rd(PORT_IRQ_ENABLE_LOW_OFS, ENABLE_LOW_RESET);
		$display("test mid_run_reset done");
		tally_and_finish();
	end
endmodule
